// *** hdl/sadc_pkg.sv ***
// Shared constants for the serial converter control link
package sadc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SADC_CLK_MHZ = 250;
  localparam int unsigned SADC_PWRUP_US = 250;
  localparam int unsigned SADC_PWRUP_CYC = SADC_PWRUP_US * SADC_CLK_MHZ;
  localparam int unsigned SADC_PROGRAM_ENABLE_LOW_CYC_DEF = 400;
  localparam int unsigned SADC_CAL_CYC_DEF = 2000;
  localparam int unsigned SADC_SCLK_HALF = 10;
  // ----------------------------------------------------------------
  // Word lengths and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] SADC_LEN_RESET = 5'h0D;
  localparam logic [4:0] SADC_LEN_SHORT = 5'h09;
  localparam int unsigned SADC_RES_W = 13;
  localparam int unsigned SADC_SR_W = 16;
  localparam int unsigned SADC_CMD_POS = 12;
  localparam int unsigned SADC_CMD_W = 4;
  localparam int unsigned SADC_CH_POS = 8;
  localparam int unsigned SADC_CH_W = 3;
  localparam logic SADC_SE_RESET = 1'b0;
  localparam int unsigned SADC_SE_POS = 11;
  // Commands in the top nibble of the shifted-in word
  localparam logic [3:0] SADC_CMD_CONV12 = 4'h0;
  localparam logic [3:0] SADC_CMD_CONV8 = 4'h1;
  localparam logic [3:0] SADC_CMD_CAL = 4'h2;
  localparam logic [3:0] SADC_CMD_ZERO = 4'h3;
  // Host register offsets
  localparam logic [3:0] SADC_REG_CTRL = 4'h0;
  localparam logic [3:0] SADC_REG_TXD = 4'h4;
  localparam logic [3:0] SADC_REG_RXD = 4'h8;
  localparam logic [3:0] SADC_REG_STAT = 4'hC;
  localparam int unsigned SADC_CTRL_GO = 0;
  localparam int unsigned SADC_CTRL_PROG = 1;
  localparam int unsigned SADC_CTRL_PD = 2;
  localparam int unsigned SADC_CTRL_HOLD = 3;
  localparam int unsigned SADC_CTRL_LEN = 8;
endpackage

// *** hdl/sadc_link_if.sv ***
// Interface joining the converter end and the host end
`timescale 1ns/10ps
interface sadc_link_if;
  logic cs_b;      // Active-low select
  logic sclk;      // Serial clock
  logic serial_in; // Data into the converter
  logic sdo;       // Data out of the converter
  logic eoc;       // End of conversion, low while busy
  logic output_ready_flag;
  logic program_enable_low;
  logic power_down_pin;
  modport dev (input cs_b, sclk, serial_in, program_enable_low, power_down_pin,
    output sdo, eoc, output_ready_flag);
  modport host (output cs_b, sclk, serial_in, program_enable_low, power_down_pin,
    input sdo, eoc, output_ready_flag);
endinterface

// *** hdl/sadc_dev.sv ***
// Converter end: serial framing, mode programming, conversion sequencing
// Summary of operation
// - Select held low: first bit at end-of-conversion rise
// - Select falling edge drives first result bit
// - Host lowers select only while clock low
// - Select fall with program enable low aborts conversion, starts new one
// - Host discards data from aborted sequences
// - Thirteen clocks per sequence after reset
// - Clock count equals programmed word length
// - Ready flag low shifting, high when done
// - Program enable low needed for commands
// - Program enable high: shift only, input ignored
// - Read-only keeps mode, starts no conversion
// - Host avoids reads while converter busy
// - Power-down pin high powers device down
// - Operational within 250 us after power-up
// - Channel bits captured on serial clock rise
// - Single-ended uses common input as reference
// - Channel decode width matches 2/4/8 variants
// - Calibration command runs calibration sequence
// - Results are twelve bits plus sign
`timescale 1ns/10ps
module sadc_dev #(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned PWRUP_CYC = sadc_pkg::SADC_PWRUP_CYC,
  parameter int unsigned PROGRAM_ENABLE_LOW_CYC = sadc_pkg::SADC_PROGRAM_ENABLE_LOW_CYC_DEF,
  parameter int unsigned CAL_CYC = sadc_pkg::SADC_CAL_CYC_DEF
) (
  input wire logic ref_clk_i,                  // Core clock
  input wire logic rst_b_i,                    // Synchronous reset, active low
  sadc_link_if.dev link,                       // Link to host
  input wire logic [sadc_pkg::SADC_RES_W-1:0] sample_i, // Digitised value, sign on top
  output logic [2:0] channel_o,                // Selected channel
  output logic single_ended_o,                 // Common input is the reference
  output logic powered_o,                      // Device operational
  output logic calibrating_o                   // Calibration or zeroing running
);
  import sadc_pkg::*;

  localparam int unsigned CHW = (NUM_CH <= 2) ? 1 : (NUM_CH <= 4) ? 2 : 3;

  typedef enum logic [3:0] {
    SADC_ST_OFF = 4'h1,
    SADC_ST_IDLE = 4'h2,
    SADC_ST_PROGRAM_ENABLE_LOW = 4'h4,
    SADC_ST_CAL = 4'h8
  } sadc_state_e;

  // ----------------------------------------------------------------
  // Input synchronisers: three stages, change accepted when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [4:0] raw_w;
  logic [4:0] s1_q, s2_q, s3_q, flt_q, flt_prev_q;
  assign raw_w = {link.power_down_pin, link.program_enable_low, link.serial_in,
                  link.sclk, link.cs_b};

  // Sync chain and filter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      // Idle pin levels, so no false edge follows reset
      s1_q <= 5'h01;
      s2_q <= 5'h01;
      s3_q <= 5'h01;
      flt_q <= 5'h01;
      flt_prev_q <= 5'h01;
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 5; i++) begin
        if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
      end
      flt_prev_q <= flt_q;
    end
  end

  logic cs_b_w, sclk_w, sin_w, prog_b_w, pd_w;
  logic cs_fall_w, sclk_rise_w, sclk_fall_w;
  assign cs_b_w = flt_q[0];
  assign sclk_w = flt_q[1];
  assign sin_w = flt_q[2];
  assign prog_b_w = flt_q[3];
  assign pd_w = flt_q[4];
  assign cs_fall_w = flt_prev_q[0] & ~cs_b_w;
  assign sclk_rise_w = ~flt_prev_q[1] & sclk_w & ~cs_b_w;
  assign sclk_fall_w = flt_prev_q[1] & ~sclk_w & ~cs_b_w;

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  sadc_state_e st_q;
  logic [31:0] tmr_q;
  logic [4:0] len_q;            // Programmed word length
  logic [4:0] bit_q;            // Bits moved in this sequence
  logic [SADC_SR_W-1:0] in_q;   // Shifted-in word
  logic [SADC_SR_W-1:0] out_q;  // Output shift register
  logic [CHW-1:0] addr_q;
  logic se_q;
  logic sdo_q, eoc_q, dor_q;
  logic seq_done_w, eoc_rise_w;
  logic [3:0] cmd_w;
  logic [SADC_SR_W-1:0] word_w; // Received word, first bit on top
  assign seq_done_w = sclk_fall_w && (bit_q == len_q - 5'h01);
  // Short frames leave the word low in the register; lift it so fields line up
  assign word_w = in_q << (5'(SADC_SR_W) - len_q);
  assign cmd_w = word_w[SADC_CMD_POS +: SADC_CMD_W];

  // Power, conversion and calibration sequencing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_q <= SADC_ST_OFF;
      tmr_q <= 32'h0;
      len_q <= SADC_LEN_RESET;
    end else if (pd_w) begin
      st_q <= SADC_ST_OFF;
      tmr_q <= 32'h0;
    end else begin
      case (st_q)
        SADC_ST_OFF: begin
          if (tmr_q >= PWRUP_CYC - 1) begin
            st_q <= SADC_ST_IDLE;
            tmr_q <= 32'h0;
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        SADC_ST_IDLE, SADC_ST_PROGRAM_ENABLE_LOW, SADC_ST_CAL: begin
          if (cs_fall_w && !prog_b_w) begin
            st_q <= SADC_ST_IDLE;
            tmr_q <= 32'h0;
          end else if (seq_done_w && !prog_b_w) begin
            tmr_q <= 32'h0;
            case (cmd_w)
              SADC_CMD_CAL, SADC_CMD_ZERO: st_q <= SADC_ST_CAL;
              SADC_CMD_CONV8: begin
                len_q <= SADC_LEN_SHORT;
                st_q <= SADC_ST_PROGRAM_ENABLE_LOW;
              end
              default: begin
                len_q <= SADC_LEN_RESET;
                st_q <= SADC_ST_PROGRAM_ENABLE_LOW;
              end
            endcase
          end else if (st_q == SADC_ST_PROGRAM_ENABLE_LOW && tmr_q >= PROGRAM_ENABLE_LOW_CYC - 1) begin
            st_q <= SADC_ST_IDLE;
          end else if (st_q == SADC_ST_CAL && tmr_q >= CAL_CYC - 1) begin
            st_q <= SADC_ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        default: st_q <= SADC_ST_OFF;
      endcase
    end
  end

  assign eoc_rise_w = (st_q == SADC_ST_PROGRAM_ENABLE_LOW) && (tmr_q >= PROGRAM_ENABLE_LOW_CYC - 1) && !pd_w
                      && !cs_fall_w && !seq_done_w;

  // End-of-conversion flag
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) eoc_q <= 1'b1;
    else eoc_q <= (st_q != SADC_ST_PROGRAM_ENABLE_LOW) && (st_q != SADC_ST_CAL);
  end

  // Input capture on serial clock rise, bit counter on serial clock fall
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      bit_q <= 5'h0;
      in_q <= '0;
    end else if (cs_fall_w || cs_b_w) begin
      bit_q <= 5'h0;
    end else begin
      if (sclk_rise_w && !prog_b_w) in_q <= {in_q[SADC_SR_W-2:0], sin_w};
      if (seq_done_w) bit_q <= 5'h0;
      else if (sclk_fall_w) bit_q <= bit_q + 5'h01;
    end
  end

  // Channel address and input configuration, held in read-only mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      addr_q <= '0;
      se_q <= SADC_SE_RESET;
    end else if (seq_done_w && !prog_b_w) begin
      addr_q <= word_w[SADC_CH_POS +: CHW];
      se_q <= word_w[SADC_SE_POS];
    end
  end

  // Output shift register: load on end of conversion, present on select fall
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      out_q <= '0;
      sdo_q <= 1'b0;
    end else if (eoc_rise_w) begin
      out_q <= {sample_i, {(SADC_SR_W-SADC_RES_W){1'b0}}};
      if (!cs_b_w) sdo_q <= sample_i[SADC_RES_W-1];
    end else if (cs_fall_w) begin
      sdo_q <= out_q[SADC_SR_W-1];
    end else if (sclk_fall_w) begin
      out_q <= {out_q[SADC_SR_W-2:0], 1'b0};
      sdo_q <= out_q[SADC_SR_W-2];
    end
  end

  // Output-ready flag: low while a sequence shifts, high after last bit
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) dor_q <= 1'b1;
    else if (seq_done_w) dor_q <= 1'b1;
    else if (cs_fall_w || eoc_rise_w && !cs_b_w) dor_q <= 1'b0;
  end

  // Registered side outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      channel_o <= 3'h0;
      single_ended_o <= 1'b0;
      powered_o <= 1'b0;
      calibrating_o <= 1'b0;
    end else begin
      channel_o <= 3'(addr_q);
      single_ended_o <= se_q;
      powered_o <= (st_q != SADC_ST_OFF);
      calibrating_o <= (st_q == SADC_ST_CAL);
    end
  end

  assign link.sdo = sdo_q;
  assign link.eoc = eoc_q;
  assign link.output_ready_flag = dor_q;
endmodule // sadc_dev

// *** hdl/sadc_host.sv ***
// Host end: serial controller with a small register port
`timescale 1ns/10ps
module sadc_host #(
  parameter int unsigned PWRUP_CYC = sadc_pkg::SADC_PWRUP_CYC // Power-up wait, core cycles
) (
  input wire logic ref_clk_i,      // Core clock
  input wire logic rst_b_i,        // Synchronous reset, active low
  input wire logic [3:0] addr_i,   // Register address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i,           // Write strobe
  input wire logic rd_i,           // Read strobe
  output logic [31:0] rdata_o,     // Read data, cycle after strobe
  sadc_link_if.host link           // Link to converter
);
  import sadc_pkg::*;

  typedef enum logic [2:0] {
    SADC_H_IDLE = 3'h1,
    SADC_H_SHIFT = 3'h2,
    SADC_H_END = 3'h4
  } sadc_hstate_e;

  // ----------------------------------------------------------------
  // Input synchronisers for converter outputs
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s2_q, s3_q, flt_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      // Idle levels: ready and end-of-conversion high, data low
      s1_q <= 3'h6;
      s2_q <= 3'h6;
      s3_q <= 3'h6;
      flt_q <= 3'h6;
    end else begin
      s1_q <= {link.output_ready_flag, link.eoc, link.sdo};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
      end
    end
  end

  sadc_hstate_e st_q;
  logic cs_b_q, sclk_q, sin_q, prog_b_q, pd_q, hold_q;
  logic [4:0] len_q, bit_q;
  logic [7:0] div_q;
  logic [SADC_SR_W-1:0] tx_q, rx_q;
  logic [31:0] pwr_tmr_q;
  logic busy_w;
  assign busy_w = (st_q != SADC_H_IDLE);

  // Control registers written by software
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prog_b_q <= 1'b0;
      pd_q <= 1'b0;
      hold_q <= 1'b0;
      len_q <= SADC_LEN_RESET;
      tx_q <= '0;
    end else if (wr_i && addr_i == SADC_REG_CTRL) begin
      prog_b_q <= wdata_i[SADC_CTRL_PROG];
      pd_q <= wdata_i[SADC_CTRL_PD];
      hold_q <= wdata_i[SADC_CTRL_HOLD];
      len_q <= wdata_i[SADC_CTRL_LEN +: 5];
    end else if (wr_i && addr_i == SADC_REG_TXD) begin
      tx_q <= wdata_i[SADC_SR_W-1:0];
    end else if (st_q == SADC_H_SHIFT && div_q == 8'(SADC_SCLK_HALF - 1) && sclk_q) begin
      tx_q <= {tx_q[SADC_SR_W-2:0], 1'b0};
    end
  end

  // Power-up wait timer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || pd_q) pwr_tmr_q <= 32'h0;
    else if (pwr_tmr_q < PWRUP_CYC) pwr_tmr_q <= pwr_tmr_q + 32'h1;
  end

  // Sequencer: select, divided serial clock, bit count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_q <= SADC_H_IDLE;
      cs_b_q <= 1'b1;
      sclk_q <= 1'b0;
      div_q <= 8'h0;
      bit_q <= 5'h0;
      rx_q <= '0;
    end else begin
      case (st_q)
        SADC_H_IDLE: begin
          sclk_q <= 1'b0;
          div_q <= 8'h0;
          bit_q <= 5'h0;
          // Start only when powered; with read-only selected, a start needs an idle converter
          if (wr_i && addr_i == SADC_REG_CTRL && wdata_i[SADC_CTRL_GO]
              && pwr_tmr_q >= PWRUP_CYC && !pd_q && (flt_q[1] || !prog_b_q)) begin
            cs_b_q <= 1'b0;
            st_q <= SADC_H_SHIFT;
          end else if (!hold_q) begin
            cs_b_q <= 1'b1;
          end
        end
        SADC_H_SHIFT: begin
          if (div_q == 8'(SADC_SCLK_HALF - 1)) begin
            div_q <= 8'h0;
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rx_q <= {rx_q[SADC_SR_W-2:0], flt_q[0]};
            end else if (bit_q == len_q - 5'h01) begin
              st_q <= SADC_H_END;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        SADC_H_END: begin
          if (!hold_q) cs_b_q <= 1'b1;
          st_q <= SADC_H_IDLE;
        end
        default: st_q <= SADC_H_IDLE;
      endcase
    end
  end

  // Serial data out is the top bit of the transmit word
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) sin_q <= 1'b0;
    else sin_q <= tx_q[SADC_SR_W-1];
  end

  // Register read port; received word is discarded by software after aborts
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        SADC_REG_CTRL: rdata_o <= {19'h0, len_q, 4'h0, hold_q, pd_q, prog_b_q, 1'b0};
        SADC_REG_TXD: rdata_o <= {16'h0, tx_q};
        SADC_REG_RXD: rdata_o <= {16'h0, rx_q};
        SADC_REG_STAT: rdata_o <= {27'h0, pwr_tmr_q >= PWRUP_CYC, flt_q[2],
                                   flt_q[1], 1'b0, busy_w};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  assign link.cs_b = cs_b_q;
  assign link.sclk = sclk_q;
  assign link.serial_in = sin_q;
  assign link.program_enable_low = prog_b_q;
  assign link.power_down_pin = pd_q;
endmodule // sadc_host

// *** testbench/sadc_link_assertions.sv ***
// Checker for the signals between converter end and host end
`timescale 1ns/10ps
module sadc_link_assertions (
  input wire logic ref_clk_i,          // Core clock
  input wire logic rst_b_i,            // Synchronous reset, active low
  input wire logic cs_b,               // Select, active low
  input wire logic sclk,               // Serial clock
  input wire logic serial_in,          // Data into converter
  input wire logic sdo,                // Data out of converter
  input wire logic eoc,                // Low while converting
  input wire logic output_ready_flag,  // Low while shifting
  input wire logic program_enable_low, // High selects read-only
  input wire logic power_down_pin      // High powers down
);
  logic sclk_q;
  logic [4:0] rise_cnt_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Delayed serial clock for edge finding
  always_ff @(posedge ref_clk_i) begin
    sclk_q <= sclk;
  end
  // Rising serial clock edges since the last ready flag rise
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || $rose(output_ready_flag)) begin
      rise_cnt_q <= 5'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_select_clk_low: assert property ($fell(cs_b) |-> !sclk)
    else $error("select fell while serial clock high");
  a_frame_clk_count: assert property ($rose(output_ready_flag) |->
    (rise_cnt_q == 5'h09 || rise_cnt_q == 5'h0D))
    else $error("frame clock count is not a word length");
  a_ready_in_frame: assert property ($fell(output_ready_flag) |-> !cs_b)
    else $error("ready flag fell outside a frame");
  a_ready_after_frame: assert property ($rose(cs_b) |-> ##[0:40] output_ready_flag)
    else $error("ready flag not high after frame");
  a_sdo_hold_high: assert property ((sclk && $past(sclk, 6) && !cs_b) |-> $stable(sdo))
    else $error("serial out moved while clock high");
  a_readonly_noconv: assert property ($fell(eoc) |-> !program_enable_low)
    else $error("conversion began in read-only mode");
  a_powered_down_idle: assert property ($fell(eoc) |-> !power_down_pin)
    else $error("conversion began while powered down");
  a_program_enable_low_bounded: assert property ($fell(eoc) |-> ##[1:600] eoc)
    else $error("end of conversion did not return high");
  a_abort_running: assert property (($fell(cs_b) && !program_enable_low && !eoc) |->
    ##[1:12] eoc)
    else $error("select fall did not abort conversion");
endmodule // sadc_link_assertions

// *** testbench/test_serial_adc_control_interface.sv ***
// Self-checking bench joining both ends of the converter link
`timescale 1ns/10ps
module test_serial_adc_control_interface;
  import sadc_pkg::*;
  localparam int unsigned PWRUP = 50;
  logic ref_clk_i, rst_b_i, wr_i, rd_i, rd_q;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [12:0] sample_i, s;
  logic [2:0] channel_o;
  logic single_ended_o, powered_o, calibrating_o;
  logic [31:0] exp_q[$], msk_q[$];
  int fail_count, checks_done, cyc;
  sadc_link_if link_if ();
  sadc_dev #(.NUM_CH(8), .PWRUP_CYC(PWRUP), .PROGRAM_ENABLE_LOW_CYC(200), .CAL_CYC(300)) u_sadc_dev (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(link_if), .sample_i(sample_i),
    .channel_o(channel_o), .single_ended_o(single_ended_o), .powered_o(powered_o),
    .calibrating_o(calibrating_o));
  sadc_host #(.PWRUP_CYC(PWRUP)) u_sadc_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .link(link_if));
  sadc_link_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .cs_b(link_if.cs_b), .sclk(link_if.sclk), .serial_in(link_if.serial_in),
    .sdo(link_if.sdo), .eoc(link_if.eoc), .output_ready_flag(link_if.output_ready_flag),
    .program_enable_low(link_if.program_enable_low),
    .power_down_pin(link_if.power_down_pin));
  // ----------------------------------------------------------------
  // Clock, shared tasks and result watcher
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Compare one seen value against its expectation
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read strobe, with the expected value noted for the watcher
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic ro, input logic [4:0] len);
    return {19'h00000, len, 4'h0, 1'b0, 1'b0, ro, 1'b1};
  endfunction
  function automatic logic [31:0] cmdw(input logic [3:0] c, input logic se,
    input logic [2:0] ch);
    return {16'h0000, c, se, ch, 8'h00};
  endfunction
  // One whole frame: load word, start, wait for the ready flag to fall and rise
  task automatic frame(input logic [31:0] txd, input logic [31:0] c);
    int n;
    wr(SADC_REG_TXD, txd);
    wr(SADC_REG_CTRL, c);
    for (n = 0; n < 40 && link_if.output_ready_flag !== 1'b0; n++) @(posedge ref_clk_i);
    for (n = 0; n < 800 && link_if.output_ready_flag !== 1'b1; n++) @(posedge ref_clk_i);
    repeat (2) @(posedge ref_clk_i);
    chk("output_ready_flag", link_if.output_ready_flag, 32'h1);
  endtask
  task automatic wait_eoc(input logic lvl);
    int n;
    for (n = 0; n < 1000 && link_if.eoc !== lvl; n++) @(posedge ref_clk_i);
    chk("eoc", link_if.eoc, {31'h0, lvl});
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk_i) begin
    rd_q <= rd_i;
    if (rd_q === 1'b1) begin
      chk("rdata", rdata_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [3:0] cmds [2];
    cmds = '{SADC_CMD_CAL, SADC_CMD_ZERO};
    rst_b_i <= 1'b0;
    addr_i <= 4'h0;
    wdata_i <= 32'h00000000;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    sample_i <= 13'h0000;
    void'($urandom(32'h35828C42));
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("powered_o", powered_o, 32'h0);
    rd(SADC_REG_STAT, 32'h0000000C, 32'h0000001D);
    rd(4'h6, 32'h00000000, 32'hFFFFFFFF);
    repeat (PWRUP + 10) @(posedge ref_clk_i);
    chk("powered_o", powered_o, 32'h1);
    // Program a conversion, then read back in read-only mode
    s = 13'($urandom);
    sample_i <= s;
    frame(cmdw(SADC_CMD_CONV12, 1'b1, 3'h5), ctl(1'b0, 5'h0D));
    chk("channel_o", channel_o, 32'h5);
    chk("single_ended_o", single_ended_o, 32'h1);
    wait_eoc(1'b0);
    wait_eoc(1'b1);
    frame(32'($urandom), ctl(1'b1, 5'h0D));
    rd(SADC_REG_RXD, {19'h00000, s}, 32'h00001FFF);
    chk("channel_o", channel_o, 32'h5);
    // Abort a running conversion with a fresh frame
    frame(cmdw(SADC_CMD_CONV12, 1'b0, 3'h3), ctl(1'b0, 5'h0D));
    wait_eoc(1'b0);
    frame(cmdw(SADC_CMD_CONV12, 1'b0, 3'h6), ctl(1'b0, 5'h0D));
    s = 13'($urandom);
    sample_i <= s;
    chk("channel_o", channel_o, 32'h6);
    wait_eoc(1'b0);
    wait_eoc(1'b1);
    frame(32'($urandom), ctl(1'b1, 5'h0D));
    rd(SADC_REG_RXD, {19'h00000, s}, 32'h00001FFF);
    // Calibration and offset zeroing
    for (i = 0; i < 2; i++) begin
      frame(cmdw(cmds[i], 1'b0, 3'h1), ctl(1'b0, 5'h0D));
      chk("calibrating_o", calibrating_o, 32'h1);
      wait_eoc(1'b1);
    end
    // Power down refuses a start, power up waits again
    wr(SADC_REG_CTRL, 32'h00000004);
    repeat (10) @(posedge ref_clk_i);
    chk("powered_o", powered_o, 32'h0);
    wr(SADC_REG_CTRL, ctl(1'b0, 5'h10) | 32'h00000004);
    repeat (30) @(posedge ref_clk_i);
    chk("cs_b", link_if.cs_b, 32'h1);
    rd(SADC_REG_STAT, 32'h00000000, 32'h00000011);
    wr(SADC_REG_CTRL, 32'h00000000);
    repeat (PWRUP / 2) @(posedge ref_clk_i);
    chk("powered_o", powered_o, 32'h0);
    repeat (PWRUP) @(posedge ref_clk_i);
    chk("powered_o", powered_o, 32'h1);
    // Short word length after the eight-bit command
    frame(cmdw(SADC_CMD_CONV8, 1'b0, 3'h2), ctl(1'b0, 5'h0D));
    chk("channel_o", channel_o, 32'h2);
    wait_eoc(1'b1);
    frame(32'($urandom), ctl(1'b1, SADC_LEN_SHORT));
    rd(SADC_REG_RXD, {23'h000000, s[12:4]}, 32'h000001FF);
    // Select held low across sequences: first bit follows end of conversion
    s = 13'($urandom);
    sample_i <= s;
    frame(cmdw(SADC_CMD_CONV12, 1'b0, 3'h4), ctl(1'b0, SADC_LEN_SHORT) | 32'h00000008);
    chk("channel_o", channel_o, 32'h4);
    wait_eoc(1'b1);
    frame(32'($urandom), ctl(1'b1, 5'h0D) | 32'h00000008);
    rd(SADC_REG_RXD, {19'h00000, s}, 32'h00001FFF);
    wr(SADC_REG_CTRL, 32'h00000D02);
    repeat (10) @(posedge ref_clk_i);
    chk("cs_b", link_if.cs_b, 32'h1);
    results();
  end
endmodule // test_serial_adc_control_interface
